// ### include/adcsr_consts.svh
`ifndef ADCSR_CONSTS_SVH
`define ADCSR_CONSTS_SVH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define ADCSR_OFS_DIAG_CTRL1     8'h15
`define ADCSR_OFS_DIAG_CTRL2     8'h16
`define ADCSR_OFS_LOAD_OHMS_CH1  8'h17
`define ADCSR_OFS_LOAD_OHMS_CH4  8'h1a
`define ADCSR_OFS_ANGLE_UPPER    8'h1b
`define ADCSR_OFS_ANGLE_LOWER    8'h1c
`define ADCSR_OFS_METRIC_UPPER   8'h1d
`define ADCSR_OFS_METRIC_LOWER   8'h1e
`define ADCSR_OFS_FAULT_CTRL     8'h21
`define ADCSR_OFS_CLIP_CTRL      8'h22
`define ADCSR_OFS_CLIP_RUN       8'h23
`define ADCSR_OFS_CLIP_FLAGS     8'h24
`define ADCSR_OFS_ILIM_FLAGS     8'h25

// ****************************************************************
// Field positions.
// ****************************************************************
`define ADCSR_FLT_CLEAR_BIT      7
`define ADCSR_FLT_SWAP_BIT       6
`define ADCSR_FLT_ILIM_MASK_BIT  5
`define ADCSR_FLT_AUTO_BIT       3
`define ADCSR_CLIP_EN_BIT        0
`define ADCSR_D1_GAIN12_BIT      7
`define ADCSR_D1_GAIN34_BIT      5
`define ADCSR_D2_LONG_BIT        4
`define ADCSR_D2_CUR_MSB         3
`define ADCSR_D2_CUR_LSB         2

// ****************************************************************
// Reset values and timing counts.
// ****************************************************************
`define ADCSR_RST_ZERO           8'h00
`define ADCSR_RST_CLIP_CTRL      8'h01
`define ADCSR_RST_CLIP_RUN       8'h14
`define ADCSR_DIAG_CYC_SHORT     7'h20
`define ADCSR_DIAG_CYC_LONG      7'h40
`define ADCSR_CUR_10MA           2'h0
`define ADCSR_CUR_19MA           2'h1

`endif

// ### include/adcsr_pkg.sv
package adcsr_pkg;

  // Serial slave states, one per phase of a byte and its acknowledge.
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } adcsr_i2c_state_t;

endpackage : adcsr_pkg

// ### hw/adcsr_sync2.sv
`timescale 1ns/1ps

// ****************************************************************
// Two-stage synchroniser for pin levels.
// ****************************************************************
module adcsr_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // The first stage feeds only the second, never any logic.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : adcsr_sync2

// ### hw/adcsr_clip_run.sv
`timescale 1ns/1ps

// ****************************************************************
// Per-channel run counter of full duty-cycle PWM periods.
// ****************************************************************
module adcsr_clip_run #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             enable,
  input  wire logic             period_tick,
  input  wire logic             full_duty,
  input  wire logic [WIDTH-1:0] run_length,
  output logic                  clipping
);

  logic [WIDTH-1:0] run_ff;
  logic             clip_ff;

  // The counter saturates so a long clip never wraps and drops the flag.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run_ff <= '0;
    end else if (!enable) begin
      run_ff <= '0;
    end else if (period_tick) begin
      if (!full_duty) begin
        run_ff <= '0;
      end else if (run_ff != {WIDTH{1'b1}}) begin
        run_ff <= run_ff + 1'b1;
      end
    end
  end

  // Clipping is reported once the run reaches the window, see R9.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clip_ff <= 1'b0;
    end else begin
      clip_ff <= enable && (run_ff >= run_length) && (run_ff != '0); // see R8
    end
  end

  assign clipping = clip_ff;

endmodule : adcsr_clip_run

// ### hw/adcsr_regbank.sv
`timescale 1ns/1ps
`include "adcsr_consts.svh"

// Operation
// R1: Each channel's load impedance is an 8-bit read-only code at 0.2496 ohm per step.
// R2: The 16-bit phase result reads as an upper byte and a lower byte, both zero after reset.
// R3: The 16-bit secondary metric reads as an upper byte and a lower byte, both zero after reset.
// R4: Writing one to bit 7 of the fault control register clears latched faults.
// R5: Bit 6 of the fault control register selects the swapped source for paralleled channels.
// R6: Bit 5 set keeps current-limit events off the warning pin, clear lets them through.
// R7: Bit 3 clear keeps a thermal shutdown latched, set lets it recover on its own.
// R8: Bit 0 of the clip control register enables clip detection and resets to one.
// R9: Clipping is reported once consecutive full-duty periods reach the window, reset 20.
// R10: The clip flag register holds one read-only flag per channel in bits 3 to 0.
// R11: The host programs the window and related settings consistently with the enable.
// R12: The current-limit register holds one read-only flag per channel, reset to zero.
// R13: Diagnostics run only on enabled channels, with per-pair gain of 1 or 4.
// R14: Diagnostics use 32 or 64 cycles and a test current of 10 mA or 19 mA.
// R15: The fault clear bit returns to zero after it has been acted on.
module adcsr_regbank
  import adcsr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h35, // Arbitrary bus address.
  parameter int         NCH      = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  input  wire logic             diag_done,
  input  wire logic [NCH*8-1:0] diag_load_ohms,
  input  wire logic [15:0]      diag_load_angle,
  input  wire logic [15:0]      diag_metric,
  output logic [NCH-1:0]        diag_channel_enable,
  output logic                  diag_gain4_ch12,
  output logic                  diag_gain4_ch34,
  output logic [6:0]            diag_cycle_count,
  output logic [1:0]            diag_test_current,
  input  wire logic             pwm_period_tick,
  input  wire logic [NCH-1:0]   pwm_full_duty,
  input  wire logic             clip_pin_mask,
  input  wire logic [NCH-1:0]   current_limit_in,
  input  wire logic             overtemp_in,
  output logic                  fault_clear,
  output logic                  parallel_source_swap,
  output logic                  thermal_shutdown,
  output logic                  warn_n
);

  // ****************************************************************
  // Pin synchronisation.
  // ****************************************************************
  logic [NCH+2:0] pins_sync;
  logic           scl_s;
  logic           sda_s;
  logic [NCH-1:0] ilim_s;
  logic           ot_s;

  adcsr_sync2 #(.WIDTH(NCH+3)) u_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in ({overtemp_in, current_limit_in, sda_in, scl_in}),
    .sync_out (pins_sync)
  );

  assign scl_s  = pins_sync[0];
  assign sda_s  = pins_sync[1];
  assign ilim_s = pins_sync[NCH+1:2];
  assign ot_s   = pins_sync[NCH+2];

  // ****************************************************************
  // Serial slave.
  // ****************************************************************
  adcsr_i2c_state_t state_ff;
  logic             scl_d_ff;
  logic             sda_d_ff;
  logic [7:0]       shift_ff;
  logic [7:0]       tx_ff;
  logic [3:0]       bit_cnt_ff;
  logic [7:0]       ptr_ff;
  logic             rw_ff;
  logic             ack_seen_ff;
  logic             drive_low_ff;
  logic             wr_stb_ff;
  logic [7:0]       wr_addr_ff;
  logic [7:0]       wr_data_ff;
  logic [7:0]       rd_byte;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_cond;
  logic             stop_cond;

  // Edge history of the synchronised bus lines.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  assign scl_rise   = scl_s && !scl_d_ff;
  assign scl_fall   = !scl_s && scl_d_ff;
  assign start_cond = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  assign stop_cond  = scl_s && scl_d_ff && !sda_d_ff && sda_s;

  // Bits are sampled on the rising clock edge and driven after the falling one,
  // so the data line only moves while the clock is low.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff     <= ST_IDLE;
      shift_ff     <= 8'h00;
      tx_ff        <= 8'h00;
      bit_cnt_ff   <= 4'h0;
      ptr_ff       <= 8'h00;
      rw_ff        <= 1'b0;
      ack_seen_ff  <= 1'b0;
      drive_low_ff <= 1'b0;
      wr_stb_ff    <= 1'b0;
      wr_addr_ff   <= 8'h00;
      wr_data_ff   <= 8'h00;
    end else begin
      wr_stb_ff <= 1'b0;
      if (start_cond) begin
        state_ff     <= ST_ADDR;
        bit_cnt_ff   <= 4'h0;
        drive_low_ff <= 1'b0;
      end else if (stop_cond) begin
        state_ff     <= ST_IDLE;
        drive_low_ff <= 1'b0;
      end else if (scl_rise) begin
        if (state_ff == ST_ADDR || state_ff == ST_PTR || state_ff == ST_WDATA) begin
          shift_ff   <= {shift_ff[6:0], sda_s};
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end else if (state_ff == ST_RDATA_ACK) begin
          ack_seen_ff <= !sda_s;
        end
      end else if (scl_fall) begin
        unique case (state_ff)
          ST_IDLE: begin
            drive_low_ff <= 1'b0;
          end
          ST_ADDR: begin
            if (bit_cnt_ff == 4'h8) begin
              if (shift_ff[7:1] == DEV_ADDR) begin
                state_ff     <= ST_ADDR_ACK;
                rw_ff        <= shift_ff[0];
                drive_low_ff <= 1'b1;
              end else begin
                state_ff <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            bit_cnt_ff <= 4'h0;
            if (rw_ff) begin
              state_ff     <= ST_RDATA;
              drive_low_ff <= !rd_byte[7];
              tx_ff        <= {rd_byte[6:0], 1'b0};
              bit_cnt_ff   <= 4'h1;
              ptr_ff       <= ptr_ff + 8'h01;
            end else begin
              state_ff     <= ST_PTR;
              drive_low_ff <= 1'b0;
            end
          end
          ST_PTR: begin
            if (bit_cnt_ff == 4'h8) begin
              state_ff     <= ST_PTR_ACK;
              ptr_ff       <= shift_ff;
              drive_low_ff <= 1'b1;
            end
          end
          ST_PTR_ACK, ST_WDATA_ACK: begin
            state_ff     <= ST_WDATA;
            bit_cnt_ff   <= 4'h0;
            drive_low_ff <= 1'b0;
          end
          ST_WDATA: begin
            if (bit_cnt_ff == 4'h8) begin
              state_ff     <= ST_WDATA_ACK;
              drive_low_ff <= 1'b1;
              wr_stb_ff    <= 1'b1;
              wr_addr_ff   <= ptr_ff;
              wr_data_ff   <= shift_ff;
              ptr_ff       <= ptr_ff + 8'h01;
            end
          end
          ST_RDATA: begin
            if (bit_cnt_ff == 4'h8) begin
              state_ff     <= ST_RDATA_ACK;
              drive_low_ff <= 1'b0;
            end else begin
              drive_low_ff <= !tx_ff[7];
              tx_ff        <= {tx_ff[6:0], 1'b0};
              bit_cnt_ff   <= bit_cnt_ff + 4'h1;
            end
          end
          ST_RDATA_ACK: begin
            if (ack_seen_ff) begin
              state_ff     <= ST_RDATA;
              drive_low_ff <= !rd_byte[7];
              tx_ff        <= {rd_byte[6:0], 1'b0};
              bit_cnt_ff   <= 4'h1;
              ptr_ff       <= ptr_ff + 8'h01;
            end else begin
              state_ff     <= ST_IDLE;
              drive_low_ff <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // Open-drain: the line is only ever pulled low.
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low_ff;

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  logic [7:0] diag_ctrl1_ff;
  logic [7:0] diag_ctrl2_ff;
  logic [7:3] fault_ctrl_ff;
  logic       clip_en_ff;
  logic [7:0] clip_run_ff;

  // Diagnostic set-up registers, all bits stored as written.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      diag_ctrl1_ff <= `ADCSR_RST_ZERO;
      diag_ctrl2_ff <= `ADCSR_RST_ZERO;
    end else if (wr_stb_ff) begin
      if (wr_addr_ff == `ADCSR_OFS_DIAG_CTRL1) diag_ctrl1_ff <= wr_data_ff;
      if (wr_addr_ff == `ADCSR_OFS_DIAG_CTRL2) diag_ctrl2_ff <= wr_data_ff;
    end
  end

  // The clear bit drops back one cycle after being set; a fresh write of one wins.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fault_ctrl_ff <= 5'h00;
    end else if (wr_stb_ff && wr_addr_ff == `ADCSR_OFS_FAULT_CTRL) begin
      fault_ctrl_ff <= wr_data_ff[7:3]; // see R4
    end else begin
      fault_ctrl_ff[`ADCSR_FLT_CLEAR_BIT] <= 1'b0; // see R15
    end
  end

  // Clip detector settings.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clip_en_ff  <= 1'(`ADCSR_RST_CLIP_CTRL >> `ADCSR_CLIP_EN_BIT); // see R8
      clip_run_ff <= `ADCSR_RST_CLIP_RUN; // see R9
    end else if (wr_stb_ff) begin
      if (wr_addr_ff == `ADCSR_OFS_CLIP_CTRL) clip_en_ff <= wr_data_ff[`ADCSR_CLIP_EN_BIT];
      if (wr_addr_ff == `ADCSR_OFS_CLIP_RUN) clip_run_ff <= wr_data_ff;
    end
  end

  assign fault_clear          = fault_ctrl_ff[`ADCSR_FLT_CLEAR_BIT];  // see R4
  assign parallel_source_swap = fault_ctrl_ff[`ADCSR_FLT_SWAP_BIT];   // see R5
  assign diag_channel_enable  = diag_ctrl1_ff[NCH-1:0];               // see R13
  assign diag_gain4_ch12      = diag_ctrl1_ff[`ADCSR_D1_GAIN12_BIT];  // see R13
  assign diag_gain4_ch34      = diag_ctrl1_ff[`ADCSR_D1_GAIN34_BIT];  // see R13
  assign diag_cycle_count     = diag_ctrl2_ff[`ADCSR_D2_LONG_BIT] ?
                                `ADCSR_DIAG_CYC_LONG : `ADCSR_DIAG_CYC_SHORT; // see R14
  // Reserved current codes fall back to the lower current as the safer choice.
  assign diag_test_current    =
    (diag_ctrl2_ff[`ADCSR_D2_CUR_MSB:`ADCSR_D2_CUR_LSB] == `ADCSR_CUR_19MA) ?
    `ADCSR_CUR_19MA : `ADCSR_CUR_10MA; // see R14

  // ****************************************************************
  // Diagnostic results.
  // ****************************************************************
  logic [7:0]  load_ohms_ff [NCH];
  logic [15:0] angle_ff;
  logic [15:0] metric_ff;

  // Channel ch takes a new impedance code when a run completes only if enable bit NCH-1-ch is set.
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ohms
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        load_ohms_ff[ch] <= `ADCSR_RST_ZERO;
      end else if (diag_done && diag_channel_enable[NCH-1-ch]) begin
        load_ohms_ff[ch] <= diag_load_ohms[ch*8 +: 8]; // see R1, R13
      end
    end
  end

  // Phase and metric words are captured together so both bytes stay coherent.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      angle_ff  <= 16'h0000;
      metric_ff <= 16'h0000;
    end else if (diag_done) begin
      angle_ff  <= diag_load_angle; // see R2
      metric_ff <= diag_metric; // see R3
    end
  end

  // ****************************************************************
  // Clip, current-limit and thermal status.
  // ****************************************************************
  logic [NCH-1:0] clip_flags;
  logic [NCH-1:0] ilim_ff;
  logic           ot_ff;
  logic           warn_n_ff;

  for (genvar ch = 0; ch < NCH; ch++) begin : g_clip
    adcsr_clip_run #(.WIDTH(8)) u_run (
      .sys_clk     (sys_clk),
      .resetn      (resetn),
      .enable      (clip_en_ff),
      .period_tick (pwm_period_tick),
      .full_duty   (pwm_full_duty[ch]),
      .run_length  (clip_run_ff),
      .clipping    (clip_flags[ch]) // see R10
    );
  end

  // Sticky current-limit flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ilim_ff <= '0;
    end else begin
      ilim_ff <= (ilim_ff & ~{NCH{fault_clear}}) | ilim_s; // see R12
    end
  end

  // Thermal shutdown holds while hot; afterwards it waits for a clear or self-releases.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ot_ff <= 1'b0;
    end else if (ot_s) begin
      ot_ff <= 1'b1;
    end else if (fault_ctrl_ff[`ADCSR_FLT_AUTO_BIT] || fault_clear) begin
      ot_ff <= 1'b0; // see R7
    end
  end

  // Warning pin, active low.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      warn_n_ff <= 1'b1;
    end else begin
      warn_n_ff <= !(((|ilim_ff) && !fault_ctrl_ff[`ADCSR_FLT_ILIM_MASK_BIT]) ||
                     ((|clip_flags) && !clip_pin_mask)); // see R6
    end
  end

  assign thermal_shutdown = ot_ff;
  assign warn_n           = warn_n_ff;

  // ****************************************************************
  // Read multiplexer.
  // ****************************************************************
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_ff >= `ADCSR_OFS_LOAD_OHMS_CH1 && ptr_ff <= `ADCSR_OFS_LOAD_OHMS_CH4) begin
      rd_byte = load_ohms_ff[2'(ptr_ff - `ADCSR_OFS_LOAD_OHMS_CH1)]; // see R1
    end
    unique case (ptr_ff)
      `ADCSR_OFS_DIAG_CTRL1:   rd_byte = diag_ctrl1_ff;
      `ADCSR_OFS_DIAG_CTRL2:   rd_byte = diag_ctrl2_ff;
      `ADCSR_OFS_ANGLE_UPPER:  rd_byte = angle_ff[15:8]; // see R2
      `ADCSR_OFS_ANGLE_LOWER:  rd_byte = angle_ff[7:0]; // see R2
      `ADCSR_OFS_METRIC_UPPER: rd_byte = metric_ff[15:8]; // see R3
      `ADCSR_OFS_METRIC_LOWER: rd_byte = metric_ff[7:0]; // see R3
      `ADCSR_OFS_FAULT_CTRL:   rd_byte = {fault_ctrl_ff, 3'b000};
      `ADCSR_OFS_CLIP_CTRL:    rd_byte = {7'h00, clip_en_ff};
      `ADCSR_OFS_CLIP_RUN:     rd_byte = clip_run_ff;
      `ADCSR_OFS_CLIP_FLAGS:   rd_byte = {{(8-NCH){1'b0}}, clip_flags}; // see R10
      `ADCSR_OFS_ILIM_FLAGS:   rd_byte = {{(8-NCH){1'b0}}, ilim_ff}; // see R12
      default: ;
    endcase
  end

endmodule : adcsr_regbank

// ### dv/adcsr_i2c_master.sv
`timescale 1ns/1ps

// ********************
// Bus host model.
// ********************
module adcsr_i2c_master (
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  localparam int HALF = 12; // Half bit, well above the slave's sync delay.

  // The bus idles released, so the pull-up holds SDA high.
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : hold

  // Data moves only while SCL is low and is sampled at the end of SCL high.
  task automatic xbit(input logic b, output logic r);
    pull <= !b;
    hold(HALF);
    scl <= 1'b1;
    hold(HALF);
    r = sda;
    scl <= 1'b0;
    hold(2);
  endtask : xbit

  // Start when b is one, stop when zero: SDA moves while SCL is high.
  task automatic cond(input logic b);
    pull <= !b;
    hold(HALF);
    scl <= 1'b1;
    hold(HALF);
    pull <= b;
    hold(HALF);
    if (b) begin
      scl <= 1'b0;
      hold(2);
    end
  endtask : cond

  // Eight bits out or in, then the acknowledge slot.
  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
                       output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
      q[i] = r;
    end
    xbit(last, r);
    ack = !r;
  endtask : xbyte

  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                    output logic ack);
    logic [7:0] q;
    logic       a1, a2, a3;
    cond(1'b1);
    xbyte({a, 1'b0}, 1'b1, q, a1);
    xbyte(p, 1'b1, q, a2);
    xbyte(d, 1'b1, q, a3);
    cond(1'b0);
    ack = a1 & a2 & a3;
  endtask : wr

  // Pointer write, repeated start, then n bytes with a closing NACK.
  task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n,
                    output logic [15:0] d);
    logic [7:0] q;
    logic       k;
    d = 16'h0000;
    cond(1'b1);
    xbyte({a, 1'b0}, 1'b1, q, k);
    xbyte(p, 1'b1, q, k);
    cond(1'b1);
    xbyte({a, 1'b1}, 1'b1, q, k);
    for (int i = 0; i < n; i++) begin
      xbyte(8'hff, i == n - 1, q, k);
      d = {d[7:0], q};
    end
    cond(1'b0);
  endtask : rd
endmodule : adcsr_i2c_master

// ### dv/adcsr_regbank_chk.sv
`timescale 1ns/1ps

// ********************
// Port checks.
// ********************
module adcsr_regbank_chk #(
  parameter logic [6:0] DEV_ADDR = 7'h35,
  parameter int         NCH      = 4
) (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       overtemp_in,
  input wire logic       fault_clear,
  input wire logic       thermal_shutdown,
  input wire logic [6:0] diag_cycle_count,
  input wire logic [1:0] diag_test_current
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  clear_pulse_a: assert property (fault_clear |=> !fault_clear)
    else $error("fault clear longer than one cycle");
  clear_slot_a: assert property (fault_clear |-> !scl_in)
    else $error("fault clear outside the bus low phase");
  heat_set_a: assert property (overtemp_in [*6] |-> thermal_shutdown)
    else $error("shutdown missing while hot");
  cool_only_a: assert property ($fell(thermal_shutdown) |-> !$past(overtemp_in))
    else $error("shutdown released while hot");
  clear_unlatch_a: assert property ((!overtemp_in) [*5] ##0 fault_clear
    |-> ##[1:3] !thermal_shutdown)
    else $error("shutdown kept after clear");
  cycle_sel_a: assert property (diag_cycle_count == 7'h20 || diag_cycle_count == 7'h40)
    else $error("bad measure length");
  current_sel_a: assert property (diag_test_current <= 2'h1)
    else $error("bad test current");
  ack_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved with clock high");
  open_drain_a: assert property (sda_out == 1'b0)
    else $error("data line driven high");
endmodule : adcsr_regbank_chk

// ### dv/tb_top.sv
`timescale 1ns/1ps

// ********************
// Register bank bench.
// ********************
module tb_top;
  localparam logic [6:0] DEV = 7'h35;
  localparam logic [7:0] OFS [10] = '{8'h17, 8'h1b, 8'h1c, 8'h1d, 8'h1e,
                                      8'h21, 8'h22, 8'h23, 8'h24, 8'h25};
  localparam logic [7:0] RST [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                      8'h00, 8'h01, 8'h14, 8'h00, 8'h00};
  logic        sys_clk = 1'b0, resetn = 1'b0, diag_done = 1'b0, tick_p = 1'b0;
  logic        clip_pin_mask = 1'b0, overtemp_in = 1'b0;
  logic        scl, pull, sda, sda_out, sda_oe, g12, g34, fault_clear, swap, thermal, warn_n;
  logic [31:0] ohms = 32'h0;
  logic [15:0] angle = 16'h0, metric = 16'h0;
  logic [3:0]  full = 4'h0, ilim = 4'h0, chan_en;
  logic [6:0]  cyc_sel;
  logic [1:0]  cur_sel;
  int          miscompares = 0, n_tests = 0, clk_cnt = 0;

  // Open-drain data line with a pull-up.
  assign sda = !(sda_oe | pull);

  // Free-running 125 MHz clock.
  always #4 sys_clk = ~sys_clk;

  adcsr_i2c_master u_adcsr_i2c_master (.sys_clk(sys_clk), .sda(sda), .scl(scl), .pull(pull));

  adcsr_regbank #(.DEV_ADDR(DEV), .NCH(4)) u_adcsr_regbank (
    .sys_clk(sys_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .diag_done(diag_done), .diag_load_ohms(ohms), .diag_load_angle(angle),
    .diag_metric(metric), .diag_channel_enable(chan_en), .diag_gain4_ch12(g12),
    .diag_gain4_ch34(g34), .diag_cycle_count(cyc_sel), .diag_test_current(cur_sel),
    .pwm_period_tick(tick_p), .pwm_full_duty(full), .clip_pin_mask(clip_pin_mask),
    .current_limit_in(ilim), .overtemp_in(overtemp_in), .fault_clear(fault_clear),
    .parallel_source_swap(swap), .thermal_shutdown(thermal), .warn_n(warn_n));

  task automatic finish_test;
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic chkb(input string n, input logic e, input logic g);
    chk(n, {15'h0, e}, {15'h0, g});
  endtask : chkb

  task automatic rdc(input logic [7:0] p, input int n, input logic [15:0] e);
    logic [15:0] d;
    u_adcsr_i2c_master.rd(DEV, p, n, d);
    chk($sformatf("reg %h", p), e, d);
  endtask : rdc

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic a;
    u_adcsr_i2c_master.wr(DEV, p, d, a);
    chkb("ack", 1'b1, a);
  endtask : wr

  // One PWM period strobe with the given full-duty pattern.
  task automatic tick(input logic [3:0] f);
    full <= f;
    tick_p <= 1'b1;
    @(posedge sys_clk);
    tick_p <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : tick

  // A hang is cut short at about twice the expected run length.
  always @(posedge sys_clk) begin
    clk_cnt <= clk_cnt + 1;
    if (clk_cnt == 90000) begin
      miscompares++;
      finish_test();
    end
  end

  // Main sequence of bus calls and expected values.
  initial begin
    logic a;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      rdc(OFS[i], 1, {8'h00, RST[i]});
    end
    wr(8'h15, 8'h09);
    ohms <= 32'hff2a_1402;
    angle <= 16'h9a5c;
    metric <= 16'h37c1;
    diag_done <= 1'b1;
    @(posedge sys_clk);
    diag_done <= 1'b0;
    rdc(8'h17, 1, 16'h0002);
    rdc(8'h1a, 1, 16'h00ff);
    rdc(8'h18, 1, 16'h0000);
    rdc(8'h1b, 2, 16'h9a5c);
    rdc(8'h1d, 2, 16'h37c1);
    wr(8'h24, 8'hff);
    rdc(8'h24, 1, 16'h0000);
    rdc(8'h30, 1, 16'h0000);
    u_adcsr_i2c_master.wr(7'h36, 8'h21, 8'h40, a);
    chkb("foreign ack", 1'b0, a);
    wr(8'h15, 8'ha9);
    wr(8'h16, 8'h14);
    chk("chan en", 16'h9, {12'h0, chan_en});
    chk("gains", 16'h3, {14'h0, g12, g34});
    chk("cycles", 16'h40, {9'h0, cyc_sel});
    chk("current", 16'h1, {14'h0, cur_sel});
    wr(8'h16, 8'h08);
    chk("cycles", 16'h20, {9'h0, cyc_sel});
    chk("current", 16'h0, {14'h0, cur_sel});
    wr(8'h21, 8'h7f);
    rdc(8'h21, 1, 16'h0078);
    chkb("swap", 1'b1, swap);
    wr(8'h21, 8'h00);
    ilim <= 4'h3;
    repeat (10) @(posedge sys_clk);
    rdc(8'h25, 1, 16'h0003);
    chkb("warn", 1'b0, warn_n);
    wr(8'h21, 8'h20);
    chkb("warn", 1'b1, warn_n);
    ilim <= 4'h0;
    wr(8'h21, 8'ha0);
    rdc(8'h25, 1, 16'h0000);
    rdc(8'h21, 1, 16'h0020);
    wr(8'h21, 8'h00);
    overtemp_in <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chkb("shutdown", 1'b1, thermal);
    overtemp_in <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chkb("shutdown", 1'b1, thermal);
    wr(8'h21, 8'h80);
    chkb("shutdown", 1'b0, thermal);
    wr(8'h21, 8'h08);
    overtemp_in <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chkb("shutdown", 1'b1, thermal);
    overtemp_in <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chkb("shutdown", 1'b0, thermal);
    wr(8'h23, 8'h03);
    tick(4'h5);
    tick(4'h5);
    rdc(8'h24, 1, 16'h0000);
    tick(4'h5);
    rdc(8'h24, 1, 16'h0005);
    chkb("warn", 1'b0, warn_n);
    clip_pin_mask <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chkb("warn", 1'b1, warn_n);
    tick(4'h1);
    rdc(8'h24, 1, 16'h0001);
    wr(8'h22, 8'h00);
    rdc(8'h24, 1, 16'h0000);
    finish_test();
  end
endmodule : tb_top

bind adcsr_regbank adcsr_regbank_chk #(.DEV_ADDR(DEV_ADDR), .NCH(NCH)) u_adcsr_regbank_chk (
  .sys_clk(sys_clk), .resetn(resetn), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .overtemp_in(overtemp_in), .fault_clear(fault_clear), .thermal_shutdown(thermal_shutdown),
  .diag_cycle_count(diag_cycle_count), .diag_test_current(diag_test_current));
